/* File: rtl/serial_port_line_control.sv */
// Line control for serial ports 2 to 7: status, flow gating, terminal-ready drive
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps

module serial_port_line_control
#(
   parameter longint BUSY_TIMEOUT_CYCLES = line_ctrl_pkg::BUSY_TIMEOUT_CYCLES
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Register port
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output      logic [15:0] rdata,
   // Controller state, same clock
   input  wire logic        running,
   input  wire logic        end_of_scan,
   input  wire logic [6:0]  maint_mode,
   // Frame engine, same clock, index 0 is port 2
   input  wire logic [5:0]  tx_start,
   input  wire logic [5:0]  rx_start,
   input  wire logic [5:0]  tx_active,
   input  wire logic [5:0]  rx_ready,
   output      logic [5:0]  tx_enable,
   output      logic [5:0]  rx_enable,
   output      logic [5:0]  tx_abort,
   // Line pins
   input  wire logic [5:0]  dsr_pin,
   output      logic [5:0]  dtr_pin,
   output      logic [5:0]  rts_pin,
   // Interrupt
   output      logic        irq
);

   localparam int NP  = line_ctrl_pkg::NUM_PORTS;
   localparam int LP  = line_ctrl_pkg::LOW_PORTS;
   localparam int FW  = line_ctrl_pkg::FLOW_W;
   localparam int OW  = line_ctrl_pkg::OUT_W;
   localparam int SW  = line_ctrl_pkg::STAT_W;
   localparam int CW  = $clog2(BUSY_TIMEOUT_CYCLES + 1);
   localparam logic [CW-1:0] LIMIT = CW'(BUSY_TIMEOUT_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Flow option decode; undefined codes fall back to no flow control
   function automatic line_ctrl_pkg::permit_type permit
   (
      input logic [2:0] flow,
      input logic       dsr
   );
      line_ctrl_pkg::permit_type p;
      p = '{tx_ok: 1'b1, rx_ok: 1'b1};
      case (flow)
         line_ctrl_pkg::FLOW_BOTH_ON:  p = '{tx_ok: dsr, rx_ok: dsr};
         line_ctrl_pkg::FLOW_BOTH_OFF: p = '{tx_ok: !dsr, rx_ok: !dsr};
         line_ctrl_pkg::FLOW_BUSY_ON:  p = '{tx_ok: dsr, rx_ok: 1'b1};
         line_ctrl_pkg::FLOW_BUSY_OFF: p = '{tx_ok: !dsr, rx_ok: 1'b1};
         default:                      p = '{tx_ok: 1'b1, rx_ok: 1'b1};
      endcase
      return p;
   endfunction

   function automatic logic [2:0] flow_clean
   (
      input logic [2:0] flow
   );
      logic [2:0] f;
      f = flow;
      if (flow > line_ctrl_pkg::FLOW_BUSY_OFF)
      begin
         f = line_ctrl_pkg::FLOW_NONE;
      end
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser; only the second stage is read
   logic [5:0] dsr_meta;
   logic [5:0] dsr_sync;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         dsr_meta <= 6'h00;
         dsr_sync <= 6'h00;
      end
      else
      begin
         dsr_meta <= dsr_pin;
         dsr_sync <= dsr_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register write decode
   logic wr_flow_lo;
   logic wr_out_lo;
   logic wr_flow_p7;
   logic wr_out_p7;
   logic wr_enable;
   logic wr_clear;

   assign wr_flow_lo = wr && (addr == line_ctrl_pkg::REG_FLOW_OPTION_LO);
   assign wr_out_lo  = wr && (addr == line_ctrl_pkg::REG_OUT_OPTION_LO);
   assign wr_flow_p7 = wr && (addr == line_ctrl_pkg::REG_FLOW_OPTION_P7);
   assign wr_out_p7  = wr && (addr == line_ctrl_pkg::REG_OUT_OPTION_P7);
   assign wr_enable  = wr && (addr == line_ctrl_pkg::REG_IRQ_ENABLE);
   assign wr_clear   = wr && (addr == line_ctrl_pkg::REG_IRQ_CLEAR);

   ////////////////////////////////////////////////////////////////////////////
   // Per port logic
   logic [15:0] status_lo_view;
   logic [15:0] flow_lo_view;
   logic [15:0] out_lo_view;
   logic [15:0] status_p7_view;
   logic [15:0] flow_p7_view;
   logic [15:0] out_p7_view;
   logic [5:0]  timeout_event;
   logic [5:0]  next_dtr;

   genvar i;
   generate
      for (i = 0; i < NP; i++)
      begin : g_port
         // Port 7 uses its own register set at the low bits
         localparam bit IS_P7 = (i == NP - 1);
         localparam int FB    = IS_P7 ? 0 : i * FW;
         localparam int OB    = IS_P7 ? 0 : i * OW;
         localparam int SB    = IS_P7 ? 0 : i * SW;

         logic [2:0]                flow_opt;
         logic [1:0]                out_opt;
         line_ctrl_pkg::option_type live;
         line_ctrl_pkg::permit_type perm;
         logic [1:0]                line_stat;
         logic [CW-1:0]             busy_cnt;
         logic                      user;
         logic                      busy_wait;
         logic                      wr_f;
         logic                      wr_o;

         assign wr_f = IS_P7 ? wr_flow_p7 : wr_flow_lo;
         assign wr_o = IS_P7 ? wr_out_p7  : wr_out_lo;

         // Options as software wrote them
         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               flow_opt <= line_ctrl_pkg::FLOW_RESET;
            end
            else if (wr_f)
            begin
               flow_opt <= wdata[FB +: FW];
            end
         end

         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               out_opt <= line_ctrl_pkg::OUT_RESET;
            end
            else if (wr_o)
            begin
               out_opt <= wdata[OB +: OW];
            end
         end

         // Options take effect only when a transfer begins
         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               live <= '{flow: line_ctrl_pkg::FLOW_RESET, out: line_ctrl_pkg::OUT_RESET};
            end
            else if (tx_start[i] || rx_start[i])
            begin
               live <= '{flow: flow_clean(flow_opt), out: out_opt};
            end
         end

         // Port index i is port i+2; bit 0 of the mode vector is port 1
         assign user = !maint_mode[i + 1];

         always_comb
         begin
            if (user)
            begin
               perm = permit(live.flow, dsr_sync[i]);
            end
            else
            begin
               perm = '{tx_ok: 1'b1, rx_ok: 1'b1};
            end
         end

         always_comb
         begin
            if (!user)
            begin
               next_dtr[i] = 1'b1;
            end
            else
            begin
               case (live.out)
                  line_ctrl_pkg::OUT_RUN:      next_dtr[i] = running;
                  line_ctrl_pkg::OUT_OFF:      next_dtr[i] = 1'b0;
                  line_ctrl_pkg::OUT_RX_READY: next_dtr[i] = running && rx_ready[i] && perm.rx_ok;
                  line_ctrl_pkg::OUT_RUN_ALT:  next_dtr[i] = running;
                  default:                     next_dtr[i] = running;
               endcase
            end
         end

         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               tx_enable[i] <= 1'b0;
               rx_enable[i] <= 1'b0;
               dtr_pin[i]   <= 1'b0;
               rts_pin[i]   <= 1'b1;
            end
            else
            begin
               tx_enable[i] <= perm.tx_ok;
               rx_enable[i] <= perm.rx_ok;
               dtr_pin[i]   <= next_dtr[i];
               rts_pin[i]   <= 1'b1;
            end
         end

         // Busy watchdog; counts only while set-ready stalls transmission under FLOW_BUSY_ON or FLOW_BUSY_OFF
         assign busy_wait = user && tx_active[i] && !perm.tx_ok &&
                            ((live.flow == line_ctrl_pkg::FLOW_BUSY_ON) ||
                             (live.flow == line_ctrl_pkg::FLOW_BUSY_OFF));

         always_ff @(posedge clk)
         begin
            if (!nrst || !busy_wait)
            begin
               busy_cnt <= '0;
            end
            else if (busy_cnt != LIMIT)
            begin
               busy_cnt <= busy_cnt + CW'(1);
            end
         end

         // One abort per stall: the counter stops at the limit
         assign timeout_event[i] = busy_wait && (busy_cnt == LIMIT - CW'(1));

         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               tx_abort[i] <= 1'b0;
            end
            else
            begin
               tx_abort[i] <= timeout_event[i];
            end
         end

         // Line status snapshot, once per scan
         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               line_stat <= 2'h0;
            end
            else if (end_of_scan)
            begin
               line_stat[line_ctrl_pkg::STAT_DTR_BIT] <= dtr_pin[i];
               line_stat[line_ctrl_pkg::STAT_DSR_BIT] <= dsr_sync[i];
            end
         end

         // Readback views
         if (IS_P7)
         begin : g_hi
            assign status_p7_view = {{(16 - SW){1'b0}}, line_stat};
            assign flow_p7_view   = {{(16 - FW){1'b0}}, flow_opt};
            assign out_p7_view    = {{(16 - OW){1'b0}}, out_opt};
         end
         else
         begin : g_lo
            assign status_lo_view[SB +: SW] = line_stat;
            assign flow_lo_view[FB +: FW]   = flow_opt;
            assign out_lo_view[OB +: OW]    = out_opt;
         end
      end
   endgenerate

   // Unused upper bits of the shared views
   assign status_lo_view[15:LP*SW] = '0;
   assign flow_lo_view[15:LP*FW]   = '0;
   assign out_lo_view[15:LP*OW]    = '0;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky timeout flags, set wins over clear
   logic [5:0] irq_status;
   logic [5:0] irq_enable;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         irq_status <= 6'h00;
      end
      else
      begin
         irq_status <= (irq_status & ~(wr_clear ? wdata[5:0] : 6'h00)) | timeout_event;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         irq_enable <= 6'h00;
      end
      else if (wr_enable)
      begin
         irq_enable <= wdata[5:0];
      end
   end

   // Looks at the updated status a cycle late; keeps the pin glitch free
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(irq_status & irq_enable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe, zero otherwise
   logic [15:0] next_rdata;

   always_comb
   begin
      case (addr)
         line_ctrl_pkg::REG_COMM_MODE_INFO: next_rdata = {9'h000, maint_mode};
         line_ctrl_pkg::REG_LINE_STATUS_LO: next_rdata = status_lo_view;
         line_ctrl_pkg::REG_FLOW_OPTION_LO: next_rdata = flow_lo_view;
         line_ctrl_pkg::REG_OUT_OPTION_LO:  next_rdata = out_lo_view;
         line_ctrl_pkg::REG_LINE_STATUS_P7: next_rdata = status_p7_view;
         line_ctrl_pkg::REG_FLOW_OPTION_P7: next_rdata = flow_p7_view;
         line_ctrl_pkg::REG_OUT_OPTION_P7:  next_rdata = out_p7_view;
         line_ctrl_pkg::REG_IRQ_STATUS:     next_rdata = {10'h000, irq_status};
         line_ctrl_pkg::REG_IRQ_ENABLE:     next_rdata = {10'h000, irq_enable};
         default:                           next_rdata = line_ctrl_pkg::DATA_ZERO;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         rdata <= line_ctrl_pkg::DATA_ZERO;
      end
      else if (rd)
      begin
         rdata <= next_rdata;
      end
      else
      begin
         rdata <= line_ctrl_pkg::DATA_ZERO;
      end
   end

endmodule

/* File: include/line_ctrl_pkg.sv */
// Constants, register map and types for the serial line control block
package line_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Geometry
   localparam int NUM_PORTS    = 6;   // Ports 2 to 7, index 0 is port 2
   localparam int LOW_PORTS    = 5;   // Ports 2 to 6 share one register set
   localparam int MODE_PORTS   = 7;   // Mode information covers ports 1 to 7
   localparam int ADDR_W       = 4;
   localparam int DATA_W       = 16;
   localparam int FLOW_W       = 3;
   localparam int OUT_W        = 2;
   localparam int STAT_W       = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices
   localparam logic [3:0] REG_COMM_MODE_INFO  = 4'h0;
   localparam logic [3:0] REG_LINE_STATUS_LO  = 4'h1;
   localparam logic [3:0] REG_FLOW_OPTION_LO  = 4'h2;
   localparam logic [3:0] REG_OUT_OPTION_LO   = 4'h3;
   localparam logic [3:0] REG_LINE_STATUS_P7  = 4'h4;
   localparam logic [3:0] REG_FLOW_OPTION_P7  = 4'h5;
   localparam logic [3:0] REG_OUT_OPTION_P7   = 4'h6;
   localparam logic [3:0] REG_IRQ_STATUS      = 4'h7;
   localparam logic [3:0] REG_IRQ_ENABLE      = 4'h8;
   localparam logic [3:0] REG_IRQ_CLEAR       = 4'h9;

   // Bit positions inside the line status field
   localparam int STAT_DSR_BIT = 0;
   localparam int STAT_DTR_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Input flow option encodings
   localparam logic [2:0] FLOW_NONE      = 3'h0;
   localparam logic [2:0] FLOW_BOTH_ON   = 3'h1;
   localparam logic [2:0] FLOW_BOTH_OFF  = 3'h2;
   localparam logic [2:0] FLOW_BUSY_ON   = 3'h3;
   localparam logic [2:0] FLOW_BUSY_OFF  = 3'h4;

   // Output option encodings
   localparam logic [1:0] OUT_RUN        = 2'h0;
   localparam logic [1:0] OUT_OFF        = 2'h1;
   localparam logic [1:0] OUT_RX_READY   = 2'h2;
   localparam logic [1:0] OUT_RUN_ALT    = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [2:0]  FLOW_RESET   = 3'h0;
   localparam logic [1:0]  OUT_RESET    = 2'h0;
   localparam logic [15:0] DATA_ZERO    = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam longint CLK_HZ              = 25000000;
   localparam longint BUSY_TIMEOUT_S      = 5;
   localparam longint BUSY_TIMEOUT_CYCLES = BUSY_TIMEOUT_S * CLK_HZ;

   ////////////////////////////////////////////////////////////////////////////
   // Options latched at the start of a transfer
   typedef struct packed
   {
      logic [2:0] flow;
      logic [1:0] out;
   } option_type;

   // Per port permission from the flow option
   typedef struct packed
   {
      logic tx_ok;
      logic rx_ok;
   } permit_type;

endpackage

/* File: test/line_ctrl_asserts.sv */
// Port-level checks for the serial line control block
`timescale 1ns/1ps
module line_ctrl_asserts
#(
   parameter longint BUSY_TIMEOUT_CYCLES = 16
)
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // Register port
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   // Controller state
   input wire logic        running,
   input wire logic        end_of_scan,
   input wire logic [6:0]  maint_mode,
   // Frame engine
   input wire logic [5:0]  tx_start,
   input wire logic [5:0]  rx_start,
   input wire logic [5:0]  tx_active,
   input wire logic [5:0]  rx_ready,
   input wire logic [5:0]  tx_enable,
   input wire logic [5:0]  rx_enable,
   input wire logic [5:0]  tx_abort,
   // Line pins and interrupt
   input wire logic [5:0]  dsr_pin,
   input wire logic [5:0]  dtr_pin,
   input wire logic [5:0]  rts_pin,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_RTS_HIGH: assert property (rts_pin == 6'h3f)
      else $error("rts not held high");
   AST_RESET_OUT: assert property (disable iff (1'b0) !nrst |=> (dtr_pin == 6'h00 && rts_pin == 6'h3f))
      else $error("bad line levels in reset");
   // Two samples of the mode so the registered pin has caught up
   AST_MAINT_DTR: assert property ($past(nrst) |-> ((maint_mode[6:1] & $past(maint_mode[6:1]) & ~dtr_pin) == 6'h00))
      else $error("dtr low in maintenance");
   AST_MAINT_EN: assert property ($past(nrst) |->
      ((maint_mode[6:1] & $past(maint_mode[6:1]) & ~(tx_enable & rx_enable)) == 6'h00))
      else $error("flow gating in maintenance");
   AST_STOP_DTR: assert property ($past(nrst) |-> ((~(maint_mode[6:1] | $past(maint_mode[6:1]))
      & {6{~running & ~$past(running)}} & dtr_pin) == 6'h00))
      else $error("dtr high while stopped");
   AST_RX_TX: assert property ((~rx_enable & tx_enable) == 6'h00)
      else $error("transmit allowed while receive blocked");
   AST_ABORT_ACTIVE: assert property ((tx_abort & ~($past(tx_active) | $past(tx_active, 2)
      | $past(tx_active, 3))) == 6'h00)
      else $error("abort without transmission");
   AST_ABORT_ONCE: assert property (tx_abort[0] |=> (!tx_abort[0]) [*4])
      else $error("repeated abort");
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside read slot");
   AST_IRQ_CAUSE: assert property ($rose(irq) |-> ($past(|tx_abort) || $past(wr, 2)))
      else $error("interrupt without cause");
endmodule

bind serial_port_line_control line_ctrl_asserts #(.BUSY_TIMEOUT_CYCLES(BUSY_TIMEOUT_CYCLES)) chk
(
   .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .running(running), .end_of_scan(end_of_scan), .maint_mode(maint_mode),
   .tx_start(tx_start), .rx_start(rx_start), .tx_active(tx_active), .rx_ready(rx_ready),
   .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_abort(tx_abort),
   .dsr_pin(dsr_pin), .dtr_pin(dtr_pin), .rts_pin(rts_pin), .irq(irq)
);

/* File: test/serial_terminal.sv */
// Remote serial terminal that shows its readiness on set-ready
`timescale 1ns/1ps
module serial_terminal
(
   // Clock
   input  wire logic       clk,
   // Readiness commanded by the bench
   input  wire logic [5:0] ready,
   // Set-ready lines toward the ports
   output      logic [5:0] dsr_pin
);
   // A cycle of own lag, as a slow printer would have
   always_ff @(posedge clk)
   begin
      dsr_pin <= ready;
   end
endmodule

/* File: test/serial_port_line_control_test.sv */
// Self-checking bench for the serial line control block
`timescale 1ns/1ps
module serial_port_line_control_test;
   localparam longint BUSY = 16;
   logic        clk, nrst, wr, rd, running, end_of_scan, irq;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata, d;
   logic [6:0]  maint_mode;
   logic [5:0]  tx_start, rx_start, tx_active, rx_ready, ready, ab;
   logic [5:0]  tx_enable, rx_enable, tx_abort, dsr_pin, dtr_pin, rts_pin;
   logic [17:0] fv;
   logic [11:0] ov, est, pst;
   logic [31:0] seed;
   logic [2:0]  e;
   int          n_mismatch, checks_done, n;

   serial_port_line_control #(.BUSY_TIMEOUT_CYCLES(BUSY)) DUT
   (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .running(running), .end_of_scan(end_of_scan), .maint_mode(maint_mode),
      .tx_start(tx_start), .rx_start(rx_start), .tx_active(tx_active), .rx_ready(rx_ready),
      .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_abort(tx_abort),
      .dsr_pin(dsr_pin), .dtr_pin(dtr_pin), .rts_pin(rts_pin), .irq(irq)
   );
   serial_terminal term (.clk(clk), .ready(ready), .dsr_pin(dsr_pin));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Expected {dtr, tx, rx}; codes 5 to 7 fall through as code 0
   function automatic logic [2:0] exp_port(input logic [2:0] f, input logic [1:0] o,
                                           input logic ds, run, rxr, mnt);
      logic tx, rx;
      tx = (f == 3'h1 || f == 3'h3) ? ds : ((f == 3'h2 || f == 3'h4) ? !ds : 1'b1);
      rx = (f == 3'h1) ? ds : ((f == 3'h2) ? !ds : 1'b1);
      if (mnt)
         return 3'h7;
      if (o == 2'h1)
         return {1'b0, tx, rx};
      if (o == 2'h2)
         return {run & rxr & rx, tx, rx};
      return {run, tx, rx};
   endfunction

   task automatic chk(input string nm, input logic [15:0] ex, got);
      checks_done++;
      if (got !== ex)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic wreg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the expected run of about 1300 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      test_done;
   end

   initial
   begin
      {nrst, wr, rd, running, end_of_scan} = 5'h00;
      addr = 4'h0;
      wdata = 16'h0000;
      maint_mode = 7'h00;
      {tx_start, rx_start, tx_active, ready} = 24'h000000;
      rx_ready = 6'h3f;
      seed = 32'he3bc;
      pst = 12'h000;
      n_mismatch = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      // Writes to read-only and unmapped places change nothing
      for (int a = 1; a < 11; a += 3)
         wreg(a[3:0], 16'hffff);
      for (int a = 0; a < 11; a++)
      begin
         rreg(a[3:0], d);
         chk("reset register", 16'h0000, d);
      end
      chk("rts", 16'h003f, {10'h000, rts_pin});
      $display("Test reset done");
      // Every flow and output code on every port, random pins and modes
      for (int r = 0; r < 32; r++)
      begin
         for (int i = 0; i < 6; i++)
         begin
            fv[3*i +: 3] = 3'(r + i);
            ov[2*i +: 2] = 2'((r >> 3) + i);
         end
         wreg(line_ctrl_pkg::REG_FLOW_OPTION_LO, {1'b0, fv[14:0]});
         wreg(line_ctrl_pkg::REG_FLOW_OPTION_P7, {13'h0000, fv[17:15]});
         wreg(line_ctrl_pkg::REG_OUT_OPTION_LO, {6'h00, ov[9:0]});
         wreg(line_ctrl_pkg::REG_OUT_OPTION_P7, {14'h0000, ov[11:10]});
         rreg(line_ctrl_pkg::REG_FLOW_OPTION_LO, d);
         chk("flow option", {1'b0, fv[14:0]}, d);
         rreg(line_ctrl_pkg::REG_OUT_OPTION_P7, d);
         chk("out option p7", {14'h0000, ov[11:10]}, d);
         rreg(line_ctrl_pkg::REG_FLOW_OPTION_P7, d);
         chk("flow option p7", {13'h0000, fv[17:15]}, d);
         rreg(line_ctrl_pkg::REG_OUT_OPTION_LO, d);
         chk("out option low", {6'h00, ov[9:0]}, d);
         @(posedge clk);
         seed = xs(seed);
         ready <= seed[5:0];
         rx_ready <= seed[11:6];
         running <= seed[12];
         maint_mode <= (r % 4 == 3) ? seed[19:13] : 7'h00;
         tx_start <= r[0] ? 6'h3f : 6'h00;
         rx_start <= r[0] ? 6'h00 : 6'h3f;
         @(posedge clk);
         {tx_start, rx_start} <= 12'h000;
         repeat (6) @(posedge clk);
         #1;
         for (int i = 0; i < 6; i++)
         begin
            e = exp_port(fv[3*i +: 3], ov[2*i +: 2], ready[i], running, rx_ready[i], maint_mode[i+1]);
            chk("dtr tx rx", {13'h0000, e}, {13'h0000, dtr_pin[i], tx_enable[i], rx_enable[i]});
            est[2*i +: 2] = {e[2], ready[i]};
         end
         rreg(line_ctrl_pkg::REG_COMM_MODE_INFO, d);
         chk("mode info", {9'h000, maint_mode}, d);
         // First pass sees the old snapshot, second the new one
         for (int k = 0; k < 2; k++)
         begin
            rreg(line_ctrl_pkg::REG_LINE_STATUS_LO, d);
            chk("status low", {6'h00, pst[9:0]}, d);
            rreg(line_ctrl_pkg::REG_LINE_STATUS_P7, d);
            chk("status p7", {14'h0000, pst[11:10]}, d);
            @(posedge clk);
            end_of_scan <= 1'b1;
            @(posedge clk);
            end_of_scan <= 1'b0;
            pst = est;
         end
      end
      $display("Test options done");
      // Busy stall on port 2 runs out; port 7 stall ends early
      {maint_mode, running} <= 8'h01;
      wreg(line_ctrl_pkg::REG_FLOW_OPTION_LO, 16'h0003);
      wreg(line_ctrl_pkg::REG_FLOW_OPTION_P7, 16'h0004);
      wreg(line_ctrl_pkg::REG_IRQ_ENABLE, 16'h0000);
      ready <= 6'h20;
      repeat (6) @(posedge clk);
      tx_start <= 6'h21;
      tx_active <= 6'h21;
      @(posedge clk);
      tx_start <= 6'h00;
      n = 0;
      ab = 6'h00;
      while (tx_abort[0] !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         if (n == 5)
            ready <= 6'h00;
         #1 n++;
         ab = ab | tx_abort;
      end
      chk("abort delay", 16'h0001, {15'h0000, n >= BUSY - 2 && n <= BUSY + 4});
      chk("early abort", 16'h0001, {10'h000, ab});
      ab = 6'h00;
      repeat (40)
      begin
         @(posedge clk);
         #1 ab = ab | tx_abort;
      end
      chk("repeat abort", 16'h0000, {10'h000, ab});
      chk("irq masked", 16'h0000, {15'h0000, irq});
      rreg(line_ctrl_pkg::REG_IRQ_STATUS, d);
      chk("irq status", 16'h0001, d);
      wreg(line_ctrl_pkg::REG_IRQ_ENABLE, 16'h0001);
      repeat (3) @(posedge clk);
      #1 chk("irq raised", 16'h0001, {15'h0000, irq});
      wreg(line_ctrl_pkg::REG_IRQ_CLEAR, 16'h0001);
      rreg(line_ctrl_pkg::REG_IRQ_STATUS, d);
      chk("irq cleared", 16'h0000, d);
      #80 chk("irq dropped", 16'h0000, {15'h0000, irq});
      @(posedge clk);
      tx_active <= 6'h00;
      $display("Test busy done");
      test_done;
   end
endmodule
